//--- logic/spio_port.sv
// Two-bank shared parallel I/O port with an APB register front end.
// Assumes a 40 MHz pclk, an APB3 master, and asynchronous pad inputs.
//
// Notes on behaviour
// - Driving peripheral takes pad; pins stay readable.
// - Idle enabled peripheral leaves pad to port.
// - Direction one is input; zero drives latch.
// - Reset sets every implemented direction bit.
// - Latch register reads and writes the latch.
// - Pin register reads pins, writes latch.
// - Absent bits disabled and read zero.
// - Analog-selected pins read low.
// - Per-pin muxes pick data and enable owner.
// - Input-only shared pins stay dedicated port.
// - Bank A direction at index 2C0, reset F6C0.
// - Bank B direction at 2C6, all ones.
// - Bank B latch at 2CB, resets zero.
// - Bank A direction governs interrupt, reference pins.
//
// The implementer's own choice: the APB register port.

`timescale 1ns/1ps
`default_nettype none

module spio_port (
    // APB clock and reset.
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave.
    input  wire logic [spio_pkg::ADDR_W-1:0] paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Bank A peripherals and pads.
    input  wire logic [15:0]                 periph_a_drive,
    input  wire logic [15:0]                 periph_a_data,
    input  wire logic [15:0]                 pad_a_in,
    output logic      [15:0]                 pad_a_out,
    output logic      [15:0]                 pad_a_oe_n,
    // Bank B peripherals and pads.
    input  wire logic [15:0]                 periph_b_drive,
    input  wire logic [15:0]                 periph_b_data,
    input  wire logic [15:0]                 pad_b_in,
    output logic      [15:0]                 pad_b_out,
    output logic      [15:0]                 pad_b_oe_n,
    // Analog selection seen by the converter.
    output logic      [15:0]                 analog_pin_config
);

    import spio_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SPIO_SEL_NONE   = 3'h0,
        SPIO_SEL_A_DIR  = 3'h1,
        SPIO_SEL_A_PIN  = 3'h2,
        SPIO_SEL_A_LAT  = 3'h3,
        SPIO_SEL_B_DIR  = 3'h4,
        SPIO_SEL_B_PIN  = 3'h5,
        SPIO_SEL_B_LAT  = 3'h6,
        SPIO_SEL_ANALOG = 3'h7
    } spio_sel_t;

    // Maps a byte address to the register it selects.
    function automatic spio_sel_t spio_decode(input logic [ADDR_W-1:0] addr);
        spio_sel_t sel;
        sel = SPIO_SEL_NONE;
        unique case (addr)
            ADDR_A_DIR:  sel = SPIO_SEL_A_DIR;
            ADDR_A_PIN:  sel = SPIO_SEL_A_PIN;
            ADDR_A_LAT:  sel = SPIO_SEL_A_LAT;
            ADDR_B_DIR:  sel = SPIO_SEL_B_DIR;
            ADDR_B_PIN:  sel = SPIO_SEL_B_PIN;
            ADDR_B_LAT:  sel = SPIO_SEL_B_LAT;
            ADDR_ANALOG: sel = SPIO_SEL_ANALOG;
            default:     sel = SPIO_SEL_NONE;
        endcase
        return sel;
    endfunction

    spio_sel_t   sel;
    logic        setup;
    logic        access;
    logic        wr;
    logic [15:0] a_dir;
    logic [15:0] a_lat;
    logic [15:0] a_pin;
    logic [15:0] b_dir;
    logic [15:0] b_lat;
    logic [15:0] b_pin;
    logic [15:0] analog_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    assign sel    = spio_decode(paddr);
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign wr     = access & pwrite;

    // Every access completes in its first access cycle, so pready is tied high.
    assign pready  = 1'b1;
    assign pslverr = access & (sel == SPIO_SEL_NONE);
    assign prdata  = rdata_reg;
    assign analog_pin_config = analog_reg;

    // ------------------------------------------------------------
    // Analog selection register
    // ------------------------------------------------------------
    // Only bank B carries converter inputs; software must also set direction there.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_reg <= ANALOG_RESET;
        end else if (wr && sel == SPIO_SEL_ANALOG) begin
            analog_reg <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Captured in the setup cycle so prdata is a flop output during access.
    // The pin value is therefore the sample present one cycle before pready.
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (sel)
            SPIO_SEL_A_DIR:  rdata_next = {16'h0000, a_dir};
            SPIO_SEL_A_PIN:  rdata_next = {16'h0000, a_pin};
            SPIO_SEL_A_LAT:  rdata_next = {16'h0000, a_lat};
            SPIO_SEL_B_DIR:  rdata_next = {16'h0000, b_dir};
            SPIO_SEL_B_PIN:  rdata_next = {16'h0000, b_pin};
            SPIO_SEL_B_LAT:  rdata_next = {16'h0000, b_lat};
            SPIO_SEL_ANALOG: rdata_next = {16'h0000, analog_reg};
            SPIO_SEL_NONE:   rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Banks
    // ------------------------------------------------------------
    // Bank A shares pins only with input-only functions, so no output owner.
    spio_bank #(
        .WIDTH      (PORT_W),
        .IMPL_MASK  (A_IMPL_MASK),
        .DIR_RESET  (A_DIR_RESET),
        .LAT_RESET  (A_LAT_RESET),
        .PERIPH_OUT (A_PERIPH_OUT)
    ) u_bank_a (
        .pclk         (pclk),
        .presetn      (presetn),
        .wr_dir       (wr && sel == SPIO_SEL_A_DIR),
        .wr_lat       (wr && (sel == SPIO_SEL_A_LAT || sel == SPIO_SEL_A_PIN)),
        .wdata        (pwdata[15:0]),
        .analog_sel   (16'h0000),
        .periph_drive (periph_a_drive),
        .periph_data  (periph_a_data),
        .pad_in       (pad_a_in),
        .pad_out      (pad_a_out),
        .pad_oe_n     (pad_a_oe_n),
        .dir_q        (a_dir),
        .lat_q        (a_lat),
        .pin_q        (a_pin)
    );

    spio_bank #(
        .WIDTH      (PORT_W),
        .IMPL_MASK  (B_IMPL_MASK),
        .DIR_RESET  (B_DIR_RESET),
        .LAT_RESET  (B_LAT_RESET),
        .PERIPH_OUT (B_PERIPH_OUT)
    ) u_bank_b (
        .pclk         (pclk),
        .presetn      (presetn),
        .wr_dir       (wr && sel == SPIO_SEL_B_DIR),
        .wr_lat       (wr && (sel == SPIO_SEL_B_LAT || sel == SPIO_SEL_B_PIN)),
        .wdata        (pwdata[15:0]),
        .analog_sel   (analog_reg),
        .periph_drive (periph_b_drive),
        .periph_data  (periph_b_data),
        .pad_in       (pad_b_in),
        .pad_out      (pad_b_out),
        .pad_oe_n     (pad_b_oe_n),
        .dir_q        (b_dir),
        .lat_q        (b_lat),
        .pin_q        (b_pin)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_periph_owns_pad: assert property (@(posedge pclk) disable iff (!presetn)
        ((pad_b_oe_n & periph_b_drive) == 16'h0000) &&
        (((pad_b_out ^ periph_b_data) & periph_b_drive) == 16'h0000))
        else $error("Driving peripheral does not own its bank B pad.");

    chk_mux_port_owner: assert property (@(posedge pclk) disable iff (!presetn)
        (((pad_b_out ^ b_lat) & ~periph_b_drive) == 16'h0000) &&
        (((pad_b_oe_n ^ b_dir) & ~periph_b_drive) == 16'h0000))
        else $error("Idle peripheral pin not driven from port latch and direction.");

    chk_input_only_port: assert property (@(posedge pclk) disable iff (!presetn)
        ((pad_a_oe_n ^ (a_dir | ~A_IMPL_MASK)) == 16'h0000) &&
        (((pad_a_out ^ a_lat) & A_IMPL_MASK) == 16'h0000))
        else $error("Bank A pad not governed by its own direction and latch.");

    chk_reset_inputs: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) == 1'b0 |-> a_dir == A_DIR_RESET && b_dir == B_DIR_RESET)
        else $error("Direction registers not all inputs after reset.");

    chk_latch_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && sel == SPIO_SEL_B_LAT |=> b_lat == $past(pwdata[15:0]))
        else $error("Bank B latch write not stored.");

    chk_pin_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && sel == SPIO_SEL_A_PIN |=> a_lat == ($past(pwdata[15:0]) & A_IMPL_MASK))
        else $error("Pin register write did not reach bank A latch.");

    chk_latch_readback: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel == SPIO_SEL_A_LAT ##1 access |-> prdata == {16'h0000, a_lat})
        else $error("Latch read returned something other than the latch.");

    chk_absent_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ((a_dir | a_lat | a_pin) & ~A_IMPL_MASK) == 16'h0000)
        else $error("Absent bank A bits do not read zero.");

    chk_analog_low: assert property (@(posedge pclk) disable iff (!presetn)
        (b_pin & analog_reg) == 16'h0000)
        else $error("Analog pin reads high through the pin register.");

    chk_pin_sample: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn, 2) |-> b_pin == ($past(pad_b_in, 2) & ~analog_reg))
        else $error("Pin register is not the two-flop sample of the pads.");

    chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        access && sel == SPIO_SEL_NONE |-> pslverr && pready)
        else $error("Unmapped access did not answer with an error.");

    // A mapped address never flags an error, and an unmapped write changes nothing.
    chk_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn)
        access && sel != SPIO_SEL_NONE |-> !pslverr)
        else $error("Mapped access answered with an error.");

    chk_unmapped_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        wr && sel == SPIO_SEL_NONE |=> $stable(a_dir) && $stable(a_lat) && $stable(b_dir) &&
        $stable(b_lat) && $stable(analog_reg))
        else $error("Unmapped write altered a register.");

    // Latches come out of reset at their reset values.
    chk_reset_latches: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) == 1'b0 |->
        a_lat == (A_LAT_RESET & A_IMPL_MASK) && b_lat == B_LAT_RESET)
        else $error("Latches not at their reset value after reset.");

    chk_dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && sel == SPIO_SEL_A_DIR |=> a_dir == ($past(pwdata[15:0]) & A_IMPL_MASK))
        else $error("Bank A direction write not stored under its mask.");

    chk_dir_write_b: assert property (@(posedge pclk) disable iff (!presetn)
        wr && sel == SPIO_SEL_B_DIR |=> b_dir == $past(pwdata[15:0]))
        else $error("Bank B direction write not stored.");

    chk_b_pin_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && sel == SPIO_SEL_B_PIN |=> b_lat == $past(pwdata[15:0]))
        else $error("Pin register write did not reach bank B latch.");

    chk_analog_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && sel == SPIO_SEL_ANALOG |=> analog_pin_config == $past(pwdata[15:0]))
        else $error("Analog selection write not stored.");

    // Reads return what the register held at the setup edge.
    chk_pin_readback: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel == SPIO_SEL_B_PIN ##1 access |->
        prdata == {16'h0000, $past(b_pin)})
        else $error("Pin read did not return the sampled pin levels.");

    chk_latch_read_b: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel == SPIO_SEL_B_LAT ##1 access |-> prdata == {16'h0000, b_lat})
        else $error("Bank B latch read returned something other than the latch.");

    chk_dir_readback: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel == SPIO_SEL_A_DIR ##1 access |-> prdata == {16'h0000, a_dir})
        else $error("Bank A direction read does not match the register.");

    chk_absent_pin_read: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && sel == SPIO_SEL_A_PIN |-> (prdata[15:0] & ~A_IMPL_MASK) == 16'h0000)
        else $error("Absent bank A pin bits read nonzero.");

    // Where no peripheral drives, the direction bit alone decides.
    chk_port_drives_latch: assert property (@(posedge pclk) disable iff (!presetn)
        ((pad_b_oe_n | (pad_b_out ^ b_lat)) & ~periph_b_drive & ~b_dir) == 16'h0000)
        else $error("Output pin not driven from its latch.");

    chk_input_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (~pad_b_oe_n & b_dir & ~periph_b_drive) == 16'h0000)
        else $error("Input pin has its driver on.");

endmodule

`default_nettype wire

//--- logic/spio_pkg.sv
// Constants shared by the parallel port bank and its register front end.
// Assumes a 32-bit APB slave whose registers each take one aligned word.

package spio_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    // One index is odd, so each index is a word number and the byte address is four times it.
    localparam logic [9:0]  IDX_A_DIR    = 10'h2C0;
    localparam logic [9:0]  IDX_A_PIN    = 10'h2C2;
    localparam logic [9:0]  IDX_A_LAT    = 10'h2C4;
    localparam logic [9:0]  IDX_B_DIR    = 10'h2C6;
    localparam logic [9:0]  IDX_B_PIN    = 10'h2C8;
    localparam logic [9:0]  IDX_B_LAT    = 10'h2CB;
    localparam logic [9:0]  IDX_ANALOG   = 10'h300;
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] ADDR_A_DIR   = {IDX_A_DIR, 2'h0};
    localparam logic [11:0] ADDR_A_PIN   = {IDX_A_PIN, 2'h0};
    localparam logic [11:0] ADDR_A_LAT   = {IDX_A_LAT, 2'h0};
    localparam logic [11:0] ADDR_B_DIR   = {IDX_B_DIR, 2'h0};
    localparam logic [11:0] ADDR_B_PIN   = {IDX_B_PIN, 2'h0};
    localparam logic [11:0] ADDR_B_LAT   = {IDX_B_LAT, 2'h0};
    localparam logic [11:0] ADDR_ANALOG  = {IDX_ANALOG, 2'h0};

    // ------------------------------------------------------------
    // Implemented bits, reset values, sharing masks
    // ------------------------------------------------------------
    localparam int          PORT_W       = 16;
    localparam logic [15:0] A_IMPL_MASK  = 16'hF6C0;
    localparam logic [15:0] A_DIR_RESET  = 16'hF6C0;
    localparam logic [15:0] A_LAT_RESET  = 16'h0000;
    localparam logic [15:0] A_PERIPH_OUT = 16'h0000;
    localparam logic [15:0] B_IMPL_MASK  = 16'hFFFF;
    localparam logic [15:0] B_DIR_RESET  = 16'hFFFF;
    localparam logic [15:0] B_LAT_RESET  = 16'h0000;
    localparam logic [15:0] B_PERIPH_OUT = 16'hFFFF;
    localparam logic [15:0] ANALOG_RESET = 16'h0000;

endpackage

//--- logic/spio_bank.sv
// One sixteen-pin parallel port bank: direction, output latch, pin sampling, pad muxes.
// Assumes pad inputs are asynchronous and peripheral drive signals come from pclk logic.

`timescale 1ns/1ps
`default_nettype none

module spio_bank #(
    parameter int               WIDTH      = 16,
    parameter logic [WIDTH-1:0] IMPL_MASK  = '1,
    parameter logic [WIDTH-1:0] DIR_RESET  = '1,
    parameter logic [WIDTH-1:0] LAT_RESET  = '0,
    parameter logic [WIDTH-1:0] PERIPH_OUT = '0
) (
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Register writes from the bus front end.
    input  wire logic             wr_dir,
    input  wire logic             wr_lat,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [WIDTH-1:0] analog_sel,
    // Peripheral side of the output muxes.
    input  wire logic [WIDTH-1:0] periph_drive,
    input  wire logic [WIDTH-1:0] periph_data,
    // Pad side.
    input  wire logic [WIDTH-1:0] pad_in,
    output logic      [WIDTH-1:0] pad_out,
    output logic      [WIDTH-1:0] pad_oe_n,
    // Register views.
    output logic      [WIDTH-1:0] dir_q,
    output logic      [WIDTH-1:0] lat_q,
    output logic      [WIDTH-1:0] pin_q
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("spio_bank: WIDTH must lie between 1 and 32.");
    end

    logic [WIDTH-1:0] dir_reg;
    logic [WIDTH-1:0] lat_reg;
    logic [WIDTH-1:0] sync1_reg;
    logic [WIDTH-1:0] sync2_reg;
    logic [WIDTH-1:0] own;

    // Direction bits reset to input; absent bits are held at zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_reg <= DIR_RESET & IMPL_MASK;
        end else if (wr_dir) begin
            dir_reg <= wdata & IMPL_MASK;
        end
    end

    // The latch takes writes aimed at either the latch or the pin register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_reg <= LAT_RESET & IMPL_MASK;
        end else if (wr_lat) begin
            lat_reg <= wdata & IMPL_MASK;
        end
    end

    // Two-stage synchroniser so a read sees one coherent sample of all pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pad_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Analog-selected pins read low whatever their voltage.
    assign pin_q = sync2_reg & IMPL_MASK & ~analog_sel;
    assign dir_q = dir_reg;
    assign lat_q = lat_reg;

    // A peripheral owns a pad only where it can drive and is driving now.
    // Input-only functions have no PERIPH_OUT bit, so the port keeps those pins.
    assign own = periph_drive & PERIPH_OUT & IMPL_MASK;

    // Data and enable muxes; absent bits never drive.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (own[i]) begin
                pad_out[i]  = periph_data[i];
                pad_oe_n[i] = 1'b0;
            end else begin
                pad_out[i]  = lat_reg[i];
                pad_oe_n[i] = dir_reg[i] | ~IMPL_MASK[i];
            end
        end
    end

endmodule

`default_nettype wire

//--- test/spio_pad_model.sv
// Pad model for one port bank: the outside world behind each pin.
// Assumes oe_n low means the block drives the pad, and a bench-set level otherwise.

`timescale 1ns/1ps
`default_nettype none

module spio_pad_model (
    // Block side of the pads.
    input  wire logic [15:0] pad_out,
    input  wire logic [15:0] pad_oe_n,
    // Level forced by the outside world on pins the block leaves alone.
    input  wire logic [15:0] ext_level,
    // Resolved pin level fed back to the block.
    output logic      [15:0] pad_in
);
    // A driven pad reads back its own level; the external source is weak.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pad_in[i] = pad_oe_n[i] ? ext_level[i] : pad_out[i];
        end
    end
endmodule

`default_nettype wire

//--- test/spio_port_test.sv
// Self-checking bench for the two-bank parallel port behind APB.
// Assumes the design package and one pad model per bank.

`timescale 1ns/1ps
`default_nettype none

module spio_port_test;
    import spio_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, dir, lat, drv, dat, ext, an;
    logic [15:0]       pa_drv, pa_dat, pb_drv, pb_dat, ext_a, ext_b, pad_a_in, pad_b_in;
    logic [15:0]       pad_a_out, pad_a_oe_n, pad_b_out, pad_b_oe_n, analog, e16, o16;
    int                n_errors, comparisons, cycles;

    // ------------------------------------------------------------
    // Design and pads
    // ------------------------------------------------------------
    spio_port i_spio_port (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_a_drive(pa_drv), .periph_a_data(pa_dat),
        .pad_a_in(pad_a_in), .pad_a_out(pad_a_out), .pad_a_oe_n(pad_a_oe_n),
        .periph_b_drive(pb_drv), .periph_b_data(pb_dat), .pad_b_in(pad_b_in),
        .pad_b_out(pad_b_out), .pad_b_oe_n(pad_b_oe_n), .analog_pin_config(analog));
    spio_pad_model i_spio_pad_model_a (.pad_out(pad_a_out), .pad_oe_n(pad_a_oe_n),
        .ext_level(ext_a), .pad_in(pad_a_in));
    spio_pad_model i_spio_pad_model_b (.pad_out(pad_b_out), .pad_oe_n(pad_b_oe_n),
        .ext_level(ext_b), .pad_in(pad_b_in));

    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    // Clock at 40 MHz.
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            test_done;
        end
    end

    // Expected active-low enable: direction, absent bits off, owning peripheral on.
    function automatic logic [15:0] exp_oe(input logic [15:0] d, m, dr);
        return (d | ~m) & ~dr;
    endfunction

    // Expected pad data: peripheral where it drives, latch elsewhere.
    function automatic logic [15:0] exp_out(input logic [15:0] l, dr, da);
        return (dr & da) | (~dr & l);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for pready.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    // Mapped reads must answer without an error flag.
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0);
    endtask

    // Let writes reach the pads and pin samples pass the synchroniser.
    task automatic settle;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic test_done;
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pa_drv, pa_dat, pb_drv, pb_dat, ext_a, ext_b} = '0;
        {n_errors, comparisons, cycles} = '0;
        presetn = 1'b0;
        void'($urandom(32'hE1AC));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ADDR_A_DIR, 32'h0000F6C0);
        rdc(ADDR_B_DIR, 32'h0000FFFF);
        rdc(ADDR_B_LAT, 32'h0);
        rdc(ADDR_ANALOG, 32'h0);
        settle;
        chk({16'h0, pad_a_oe_n}, 32'h0000FFFF);
        chk({16'h0, pad_b_oe_n}, 32'h0000FFFF);
        // Bank A: absent bits, pin writes into the latch, peripherals ignored.
        for (int i = 0; i < 8; i++) begin
            dir = (i == 0) ? 32'hFFFF0000 : $urandom;
            lat = $urandom;
            wr(ADDR_A_DIR, dir);
            wr(ADDR_A_PIN, lat);
            rdc(ADDR_A_DIR, {16'h0, dir[15:0] & A_IMPL_MASK});
            rdc(ADDR_A_LAT, {16'h0, lat[15:0] & A_IMPL_MASK});
            @(posedge pclk);
            ext_a  <= 16'($urandom);
            pa_drv <= 16'($urandom);
            pa_dat <= 16'($urandom);
            settle;
            e16 = exp_oe(dir[15:0], A_IMPL_MASK, 16'h0);
            chk({16'h0, pad_a_oe_n}, {16'h0, e16});
            chk({16'h0, pad_a_out & ~e16}, {16'h0, lat[15:0] & ~e16});
            rdc(ADDR_A_PIN, {16'h0, ((e16 & ext_a) | (~e16 & lat[15:0])) & A_IMPL_MASK});
        end
        // Bank B: peripheral ownership against port direction and latch.
        for (int i = 0; i < 8; i++) begin
            dir = (i == 1) ? 32'h0 : $urandom;
            lat = $urandom;
            drv = (i == 0) ? 32'hFFFF : ((i == 1) ? 32'h0 : $urandom);
            dat = $urandom;
            ext = $urandom;
            wr(ADDR_B_DIR, dir);
            // Odd passes reach the latch through the pin register.
            wr(i[0] ? ADDR_B_PIN : ADDR_B_LAT, lat);
            @(posedge pclk);
            pb_drv <= drv[15:0];
            pb_dat <= dat[15:0];
            ext_b  <= ext[15:0];
            settle;
            e16 = exp_oe(dir[15:0], 16'hFFFF, drv[15:0]);
            o16 = exp_out(lat[15:0], drv[15:0], dat[15:0]);
            chk({16'h0, pad_b_oe_n}, {16'h0, e16});
            chk({16'h0, pad_b_out}, {16'h0, o16});
            rdc(ADDR_B_PIN, {16'h0, (e16 & ext[15:0]) | (~e16 & o16)});
            rdc(ADDR_B_LAT, {16'h0, lat[15:0]});
        end
        // Analog pins read low whatever the outside level.
        wr(ADDR_B_DIR, 32'h0000FFFF);
        an = $urandom;
        wr(ADDR_ANALOG, an);
        @(posedge pclk);
        pb_drv <= 16'h0;
        ext_b  <= 16'hFFFF;
        settle;
        chk({16'h0, analog}, {16'h0, an[15:0]});
        rdc(ADDR_B_PIN, {16'h0, ~an[15:0]});
        // Unmapped address: error flag, write dropped, read zero.
        apb(1'b1, 12'h004, 32'hFFFF, rd, err);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h004, 32'h0, rd, err);
        chk(rd, 32'h0);
        rdc(ADDR_ANALOG, {16'h0, an[15:0]});
        // Reset in mid-run returns the pins to inputs.
        wr(ADDR_A_DIR, 32'h0);
        wr(ADDR_B_LAT, 32'hFFFF);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ADDR_A_DIR, 32'h0000F6C0);
        rdc(ADDR_B_LAT, 32'h0);
        @(negedge pclk);
        chk({16'h0, pad_a_oe_n}, 32'h0000FFFF);
        chk({16'h0, pad_b_oe_n}, 32'h0000FFFF);
        test_done;
    end
endmodule

`default_nettype wire
